// *** lcd_byte_rx.v ***
// lcd_byte_rx.v: assembles host bytes from serial bits or parallel nibbles
// assumes: pins are asynchronous to clock; interface mode strap given by parent
`timescale 1ns/1ps
`include "lcd_defs.vh"

module lcd_byte_rx (
   input wire clock,
   input wire srst,
   input wire parallel_mode,
   input wire cs_n,
   input wire strobe_n,
   input wire cmd_sel,
   input wire [3:0] data_pins,
   output reg byte_valid,
   output reg [7:0] byte_data,
   output reg byte_is_cmd
);

   // ----------------------------------------
   // two-stage synchronisers
   // ----------------------------------------
   wire [6:0] pins_raw;
   wire [6:0] pins_sync;
   assign pins_raw = {cs_n, strobe_n, cmd_sel, data_pins};

   genvar gi;
   generate
      for (gi = 0; gi < 7; gi = gi + 1) begin : g_sync
         reg stage1;
         reg stage2;
         always @(posedge clock) begin
            if (srst) begin
               stage1 <= 1'b1;
               stage2 <= 1'b1;
            end else begin
               stage1 <= pins_raw[gi];
               stage2 <= stage1;
            end
         end
         assign pins_sync[gi] = stage2;
      end
   endgenerate

   wire cs_n_s;
   wire strobe_s;
   wire cmd_s;
   wire [3:0] data_s;
   assign cs_n_s = pins_sync[6];
   assign strobe_s = pins_sync[5];
   assign cmd_s = pins_sync[4];
   assign data_s = pins_sync[3:0];

   // ----------------------------------------
   // edge detect and assembly
   // ----------------------------------------
   reg strobe_prev;
   reg [2:0] bit_count;
   reg [6:0] shift;
   wire strobe_rise;
   assign strobe_rise = strobe_s & ~strobe_prev & ~cs_n_s;

   always @(posedge clock) begin
      if (srst) begin
         strobe_prev <= 1'b1;
         bit_count <= 3'h0;
         shift <= 7'h00;
         byte_valid <= 1'b0;
         byte_data <= 8'h00;
         byte_is_cmd <= 1'b0;
      end else begin
         strobe_prev <= strobe_s;
         byte_valid <= 1'b0;
         if (cs_n_s) begin
            bit_count <= 3'h0;
         end else if (strobe_rise) begin
            if (parallel_mode) begin
               if (bit_count == 3'h0) begin
                  shift[6:3] <= data_s;
                  bit_count <= 3'h1;
               end else begin
                  byte_data <= {shift[6:3], data_s};
                  byte_is_cmd <= cmd_s;
                  byte_valid <= 1'b1;
                  bit_count <= 3'h0;
               end
            end else begin
               shift <= {shift[5:0], data_s[0]};
               bit_count <= bit_count + 3'h1;
               if (bit_count == 3'h7) begin
                  byte_data <= {shift, data_s[0]};
                  byte_is_cmd <= cmd_s;
                  byte_valid <= 1'b1;
               end
            end
         end
      end
   end

endmodule

// *** lcd_cmd_assertions.sv ***
// checker: timing relations on the decoder ports
// assumes: bound to lcd_command_decoder; one clock, sync reset
`timescale 1ns/1ps
module lcd_cmd_chk #(
   parameter BUSY_CYCLES = 18
) (
   input wire clock,
   input wire srst,
   input wire busy_n,
   input wire [2:0] frame_div,
   input wire [1:0] access_mode,
   input wire char_mode,
   input wire char_right_entry,
   input wire bit_op,
   input wire stop_mode,
   input wire data_valid,
   input wire [7:0] data_byte
);
   reg [7:0] low_cnt;
   always @(posedge clock) begin
      if (srst || busy_n) begin
         low_cnt <= 8'h00;
      end else begin
         low_cnt <= low_cnt + 8'h01;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   sequence busy_start;
      $fell(busy_n) ##1 !busy_n;
   endsequence
   busy_len_a: assert property ($rose(busy_n) |-> low_cnt == BUSY_CYCLES)
      else $error("busy low time wrong");
   pulse_start_a: assert property (bit_op || data_valid |-> busy_start)
      else $error("pulse outside busy start");
   pulse_excl_a: assert property (bit_op |-> !data_valid ##1 !bit_op)
      else $error("bit pulse bad");
   frame_upd_a: assert property (!$past(srst) && $changed(frame_div) |-> $fell(busy_n))
      else $error("frame change off busy start");
   entry_mode_a: assert property (!$past(srst) && $changed(char_right_entry) |-> char_mode)
      else $error("entry change without char mode");
   access_char_a: assert property (!$past(srst) && $changed(access_mode) |-> !char_mode)
      else $error("access change kept char mode");
   stop_hold_a: assert property (!$past(srst) |-> !$fell(stop_mode))
      else $error("stop mode left");
   data_hold_a: assert property (!$past(srst) && $changed(data_byte) |-> data_valid)
      else $error("data byte changed alone");
endmodule
bind lcd_command_decoder lcd_cmd_chk #(.BUSY_CYCLES(BUSY_CYCLES)) chk_u (.clock(clock), .srst(srst),
   .busy_n(busy_n), .frame_div(frame_div), .access_mode(access_mode), .char_mode(char_mode),
   .char_right_entry(char_right_entry), .bit_op(bit_op), .stop_mode(stop_mode),
   .data_valid(data_valid), .data_byte(data_byte));

// *** lcd_cmd_host.sv ***
// host model: writes whole bytes to the decoder pins
// assumes: bench calls send; lines change at falling clock edges
`timescale 1ns/1ps
module lcd_cmd_host (
   input wire clock,
   input wire busy_n,
   output reg cs_n,
   output reg strobe_n,
   output reg cmd_sel,
   output reg [3:0] data_pins
);
   integer i;
   integer n;
   initial begin
      cs_n = 1'b1;
      strobe_n = 1'b1;
      cmd_sel = 1'b0;
      data_pins = 4'h0;
   end
   // one byte msb first, then wait out busy and release the lines
   task send(input par, input cd, input [7:0] b);
      begin
         @(negedge clock);
         cs_n = 1'b0;
         cmd_sel = cd;
         for (i = 0; i < (par ? 2 : 8); i = i + 1) begin
            data_pins = par ? b[7-4*i -: 4] : {3'h0, b[7-i]};
            strobe_n = 1'b0;
            repeat (3) @(negedge clock);
            strobe_n = 1'b1;
            repeat (3) @(negedge clock);
         end
         n = 0;
         while (busy_n && n < 12) begin
            @(negedge clock);
            n = n + 1;
         end
         while (!busy_n && n < 60) begin
            @(negedge clock);
            n = n + 1;
         end
         cs_n = 1'b1;
         cmd_sel = ~cmd_sel;
         data_pins = ~data_pins;
      end
   endtask
endmodule

// *** lcd_command_decoder.v ***
// lcd_command_decoder.v: command decoder of a dot-matrix lcd controller
// assumes: host writes bytes over 4-bit parallel or serial pins; one clock, sync reset
`timescale 1ns/1ps
`include "lcd_defs.vh"

module lcd_command_decoder #(
   parameter BUSY_CYCLES = `LCD_BUSY_CYCLES
) (
   input wire clock,
   input wire srst,
   input wire par_ser_strap,
   input wire cs_n,
   input wire strobe_n,
   input wire cmd_sel,
   input wire [3:0] data_pins,
   output reg busy_n,
   output reg [2:0] frame_div,
   output reg [2:0] mux_mode,
   output reg display_on,
   output reg [6:0] data_pointer,
   output reg [1:0] access_mode,
   output reg [1:0] pointer_step,
   output reg char_mode,
   output reg char_right_entry,
   output reg bit_op,
   output reg bit_value,
   output reg [2:0] bit_index,
   output reg cursor_on,
   output reg stop_mode,
   output reg data_valid,
   output reg [7:0] data_byte
);

   // ----------------------------------------
   // range check
   // ----------------------------------------
   function in_range;
      input [7:0] code;
      input [7:0] first;
      input [7:0] last;
      begin
         in_range = (code >= first) && (code <= last);
      end
   endfunction

   // ----------------------------------------
   // command classes
   // ----------------------------------------
   localparam [3:0] KIND_NONE = 4'h0;
   localparam [3:0] KIND_STOP = 4'h1;
   localparam [3:0] KIND_DISP_OFF = 4'h2;
   localparam [3:0] KIND_DISP_ON = 4'h3;
   localparam [3:0] KIND_FRAME = 4'h4;
   localparam [3:0] KIND_MUX = 4'h5;
   localparam [3:0] KIND_BIT = 4'h6;
   localparam [3:0] KIND_ACCESS = 4'h7;
   localparam [3:0] KIND_CHAR_LEFT = 4'h8;
   localparam [3:0] KIND_CHAR_RIGHT = 4'h9;
   localparam [3:0] KIND_CURS_CLR = 4'hA;
   localparam [3:0] KIND_CURS_WR = 4'hB;
   localparam [3:0] KIND_PTR = 4'hC;

   // sorts a command byte into one class; undefined codes fall to none
   function [3:0] cmd_kind;
      input [7:0] code;
      begin
         if (code == `LCD_STOP_CODE) begin
            cmd_kind = KIND_STOP;
         end else if (code == `LCD_DISP_OFF_CODE) begin
            cmd_kind = KIND_DISP_OFF;
         end else if (code == `LCD_DISP_ON_CODE) begin
            cmd_kind = KIND_DISP_ON;
         end else if (in_range(code, `LCD_FRAME_FIRST, `LCD_FRAME_LAST)) begin
            cmd_kind = KIND_FRAME;
         end else if (in_range(code, `LCD_MUX_FIRST, `LCD_MUX_LAST)) begin
            cmd_kind = KIND_MUX;
         end else if (in_range(code, `LCD_BITCLR_FIRST, `LCD_BITSET_LAST)) begin
            cmd_kind = KIND_BIT;
         end else if (in_range(code, `LCD_ACCESS_FIRST, `LCD_ACCESS_LAST)) begin
            cmd_kind = KIND_ACCESS;
         end else if (code == `LCD_CHAR_LEFT_CODE) begin
            cmd_kind = KIND_CHAR_LEFT;
         end else if (code == `LCD_CHAR_RIGHT_CODE) begin
            cmd_kind = KIND_CHAR_RIGHT;
         end else if (code == `LCD_CURS_CLR_CODE) begin
            cmd_kind = KIND_CURS_CLR;
         end else if (code == `LCD_CURS_WR_CODE) begin
            cmd_kind = KIND_CURS_WR;
         end else if (in_range(code, `LCD_PTR_LO_FIRST, `LCD_PTR_LO_LAST) ||
                      in_range(code, `LCD_PTR_HI_FIRST, `LCD_PTR_HI_LAST)) begin
            cmd_kind = KIND_PTR;
         end else begin
            cmd_kind = KIND_NONE;
         end
      end
   endfunction

   // ----------------------------------------
   // interface strap, caught while reset is held
   // ----------------------------------------
   reg strap_s1;
   reg strap_s2;
   reg parallel_mode;
   always @(posedge clock) begin
      strap_s1 <= par_ser_strap;
      strap_s2 <= strap_s1;
      if (srst) begin
         parallel_mode <= strap_s2;
      end
   end

   // ----------------------------------------
   // byte receiver
   // ----------------------------------------
   wire byte_valid;
   wire [7:0] byte_data;
   wire byte_is_cmd;

   lcd_byte_rx u_rx (
      .clock(clock),
      .srst(srst),
      .parallel_mode(parallel_mode),
      .cs_n(cs_n),
      .strobe_n(strobe_n),
      .cmd_sel(cmd_sel),
      .data_pins(data_pins),
      .byte_valid(byte_valid),
      .byte_data(byte_data),
      .byte_is_cmd(byte_is_cmd)
   );

   // ----------------------------------------
   // busy timer
   // ----------------------------------------
   reg [7:0] busy_count;
   always @(posedge clock) begin
      if (srst) begin
         busy_n <= 1'b1;
         busy_count <= 8'h00;
      end else if (byte_valid && busy_n) begin
         busy_n <= 1'b0;
         busy_count <= BUSY_CYCLES[7:0] - 8'h01;
      end else if (!busy_n) begin
         if (busy_count == 8'h00) begin
            busy_n <= 1'b1;
         end else begin
            busy_count <= busy_count - 8'h01;
         end
      end
   end

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   wire take;
   wire take_cmd;
   assign take = byte_valid & busy_n;
   assign take_cmd = take & byte_is_cmd;

   wire [3:0] cmd_class;
   assign cmd_class = cmd_kind(byte_data);

   always @(posedge clock) begin
      if (srst) begin
         frame_div <= `LCD_RST_FRAME;
         mux_mode <= `LCD_RST_MUX;
         display_on <= 1'b0;
         data_pointer <= `LCD_RST_PTR;
         access_mode <= `LCD_RST_MODE;
         pointer_step <= `LCD_RST_STEP;
         char_mode <= 1'b0;
         char_right_entry <= 1'b0;
         bit_op <= 1'b0;
         bit_value <= 1'b0;
         bit_index <= 3'h0;
         cursor_on <= 1'b0;
         stop_mode <= 1'b0;
         data_valid <= 1'b0;
         data_byte <= 8'h00;
      end else begin
         bit_op <= 1'b0;
         data_valid <= 1'b0;
         if (take && !byte_is_cmd) begin
            data_byte <= byte_data;
            data_valid <= 1'b1;
         end
         if (take_cmd) begin
            case (cmd_class)
               KIND_STOP: begin
                  stop_mode <= 1'b1;
               end
               KIND_DISP_OFF: begin
                  display_on <= 1'b0;
               end
               KIND_DISP_ON: begin
                  display_on <= 1'b1;
               end
               KIND_FRAME: begin
                  frame_div <= byte_data[`LCD_SEL_MSB:0];
               end
               KIND_MUX: begin
                  mux_mode <= byte_data[`LCD_SEL_MSB:0];
               end
               KIND_BIT: begin
                  bit_op <= 1'b1;
                  bit_value <= in_range(byte_data, `LCD_BITSET_FIRST, `LCD_BITSET_LAST);
                  bit_index <= byte_data[`LCD_BIT_MSB:`LCD_BIT_LSB];
                  pointer_step <= byte_data[`LCD_STEP_MSB:0];
               end
               KIND_ACCESS: begin
                  access_mode <= byte_data[`LCD_MODE_MSB:`LCD_MODE_LSB];
                  pointer_step <= byte_data[`LCD_STEP_MSB:0];
                  char_mode <= 1'b0;
               end
               KIND_CHAR_LEFT: begin
                  char_mode <= 1'b1;
                  char_right_entry <= 1'b0;
               end
               KIND_CHAR_RIGHT: begin
                  char_mode <= 1'b1;
                  char_right_entry <= 1'b1;
               end
               KIND_CURS_CLR: begin
                  cursor_on <= 1'b0;
               end
               KIND_CURS_WR: begin
                  cursor_on <= 1'b1;
               end
               KIND_PTR: begin
                  data_pointer <= byte_data[`LCD_PTR_MSB:0];
               end
               default: begin
                  stop_mode <= stop_mode;
               end
            endcase
         end
      end
   end

endmodule

// *** lcd_command_decoder_tb_top.sv ***
// bench: drives command and data bytes, checks decoded fields
// assumes: host model lcd_cmd_host, checker bound to the decoder
`timescale 1ns/1ps
module lcd_command_decoder_tb_top;
   reg clock = 1'b0;
   reg srst = 1'b1;
   reg strap = 1'b0;
   reg [7:0] cap = 8'h00;
   integer fails = 0;
   integer checks = 0;
   integer cyc = 0;
   integer pulses = 0;
   integer p;
   integer k;
   wire cs_n, strobe_n, cmd_sel, busy_n, display_on, char_mode, char_right_entry;
   wire bit_op, bit_value, cursor_on, stop_mode, data_valid;
   wire [3:0] data_pins;
   wire [2:0] frame_div, mux_mode, bit_index;
   wire [6:0] data_pointer;
   wire [1:0] access_mode, pointer_step;
   wire [7:0] data_byte;
   lcd_cmd_host host_u (.clock(clock), .busy_n(busy_n), .cs_n(cs_n), .strobe_n(strobe_n),
      .cmd_sel(cmd_sel), .data_pins(data_pins));
   lcd_command_decoder #(.BUSY_CYCLES(18)) dut_u (.clock(clock), .srst(srst), .par_ser_strap(strap),
      .cs_n(cs_n), .strobe_n(strobe_n), .cmd_sel(cmd_sel), .data_pins(data_pins), .busy_n(busy_n),
      .frame_div(frame_div), .mux_mode(mux_mode), .display_on(display_on), .data_pointer(data_pointer),
      .access_mode(access_mode), .pointer_step(pointer_step), .char_mode(char_mode),
      .char_right_entry(char_right_entry), .bit_op(bit_op), .bit_value(bit_value), .bit_index(bit_index),
      .cursor_on(cursor_on), .stop_mode(stop_mode), .data_valid(data_valid), .data_byte(data_byte));
   initial begin
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (bit_op || data_valid) begin
         pulses = pulses + 1;
         cap = {data_valid, 3'h0, bit_value, bit_index};
      end
      if (cyc == 20000) begin
         fails = fails + 1;
         $display("[FAIL] %0t timeout", $time);
         end_sim;
      end
   end
   task chk(input ok, input [8*8-1:0] what);
      begin
         checks = checks + 1;
         if (ok !== 1'b1) begin
            fails = fails + 1;
            $display("[FAIL] %0t %0s", $time, what);
         end
      end
   endtask
   task rst(input s);
      begin
         @(negedge clock);
         srst = 1'b1;
         strap = s;
         repeat (5) @(negedge clock);
         srst = 1'b0;
         repeat (2) @(negedge clock);
      end
   endtask
   task cmd(input [7:0] b);
      host_u.send(strap, 1'b1, b);
   endtask
   task t_frame;
      begin
         for (k = 0; k < 5; k = k + 1) begin
            cmd(8'h10 + k[7:0]);
            chk(frame_div === k[2:0], "frame");
         end
         cmd(8'h15);
         chk(frame_div === 3'h4, "undef");
         cmd(8'h18);
         chk(mux_mode === 3'h0, "mux lo");
         cmd(8'h1F);
         chk(mux_mode === 3'h7, "mux hi");
      end
   endtask
   task t_ptr;
      begin
         cmd(8'hB1);
         chk(data_pointer === 7'h31, "ptr b1");
         cmd(8'hB2);
         chk(data_pointer === 7'h31, "ptr b2");
         cmd(8'hF1);
         chk(data_pointer === 7'h71, "ptr f1");
         cmd(8'hFF);
         chk(data_pointer === 7'h71, "ptr ff");
      end
   endtask
   task t_mode;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            cmd(8'h60 + 5 * k[7:0]);
            chk(access_mode === k[1:0] && pointer_step === k[1:0], "access");
         end
         cmd(8'h71);
         chk(char_mode === 1'b1 && char_right_entry === 1'b0, "left");
         cmd(8'h72);
         chk(char_mode === 1'b1 && char_right_entry === 1'b1, "right");
         cmd(8'h64);
         chk(char_mode === 1'b0 && access_mode === 2'h1, "wr mode");
      end
   endtask
   task t_bit;
      begin
         p = pulses;
         cmd(8'h3F);
         chk(pulses == p + 1 && cap === 8'h07 && pointer_step === 2'h3, "clr bit");
         cmd(8'h40);
         chk(pulses == p + 2 && cap === 8'h08 && pointer_step === 2'h0, "set bit");
         host_u.send(strap, 1'b0, 8'h09);
         chk(pulses == p + 3 && data_byte === 8'h09 && display_on === 1'b0, "data");
         cmd(8'h01);
         chk(stop_mode === 1'b1, "stop");
      end
   endtask
   task t_par;
      begin
         rst(1'b1);
         chk(stop_mode === 1'b0 && access_mode === 2'h1, "reset");
         cmd(8'h09);
         chk(display_on === 1'b1, "disp on");
         cmd(8'hC3);
         chk(data_pointer === 7'h43, "par ptr");
         cmd(8'h7D);
         chk(cursor_on === 1'b1, "curs on");
         cmd(8'h7C);
         cmd(8'h08);
         chk(cursor_on === 1'b0 && display_on === 1'b0, "offs");
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d fails %0d", checks, fails);
         if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
         end else begin
            $display("MISMATCHES SEEN");
         end
         $finish;
      end
   endtask
   initial begin
      rst(1'b0);
      t_frame;
      t_ptr;
      t_mode;
      t_bit;
      t_par;
      end_sim;
   end
endmodule

// *** lcd_defs.vh ***
// lcd_defs.vh: command codes, field positions, reset values and timing counts
// assumes: included by the command decoder and its byte receiver
`ifndef LCD_DEFS_VH
`define LCD_DEFS_VH

// ----------------------------------------
// command code ranges
// ----------------------------------------
`define LCD_STOP_CODE 8'h01
`define LCD_DISP_OFF_CODE 8'h08
`define LCD_DISP_ON_CODE 8'h09
`define LCD_FRAME_FIRST 8'h10
`define LCD_FRAME_LAST 8'h14
`define LCD_MUX_FIRST 8'h18
`define LCD_MUX_LAST 8'h1F
`define LCD_BITCLR_FIRST 8'h20
`define LCD_BITCLR_LAST 8'h3F
`define LCD_BITSET_FIRST 8'h40
`define LCD_BITSET_LAST 8'h5F
`define LCD_ACCESS_FIRST 8'h60
`define LCD_ACCESS_LAST 8'h6F
`define LCD_CHAR_LEFT_CODE 8'h71
`define LCD_CHAR_RIGHT_CODE 8'h72
`define LCD_CURS_CLR_CODE 8'h7C
`define LCD_CURS_WR_CODE 8'h7D
`define LCD_PTR_LO_FIRST 8'h80
`define LCD_PTR_LO_LAST 8'hB1
`define LCD_PTR_HI_FIRST 8'hC0
`define LCD_PTR_HI_LAST 8'hF1

// ----------------------------------------
// field positions
// ----------------------------------------
`define LCD_SEL_MSB 2
`define LCD_STEP_MSB 1
`define LCD_MODE_MSB 3
`define LCD_MODE_LSB 2
`define LCD_BIT_MSB 4
`define LCD_BIT_LSB 2
`define LCD_PTR_MSB 6

// ----------------------------------------
// access modes
// ----------------------------------------
`define LCD_MODE_READ 2'h0
`define LCD_MODE_WRITE 2'h1
`define LCD_MODE_OR 2'h2
`define LCD_MODE_AND 2'h3

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define LCD_RST_FRAME 3'h0
`define LCD_RST_MUX 3'h0
`define LCD_RST_PTR 7'h00
`define LCD_RST_MODE 2'h1
`define LCD_RST_STEP 2'h0
`define LCD_BUSY_CYCLES 18
`define LCD_BYTE_BITS 8

`endif
